// ==== tsn_regs.sv ====
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Test pattern two low byte at 0x1B.
// - Test pattern three: 0x1D low, 0x1E high.
// - Test pattern four: 0x1F low, 0x20 high.
// - Mode 000 is 22%, 001 is 33%.
// - Tuning word meaning depends on mode; 7:6 unused.
// - Master sync bit gates all sync functions.
// - Sync reaches divider only when bits 1,0 high.
// - Control bit 0 enables or bypasses requantizer.
// - Tuning steps 0.5%; 57 or 34 valid words.
module tsn_regs
	import tsn_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// register access from the serial port engine
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// external sync pin
	input wire logic sync_pin,
	// sync side outputs
	output logic sync_buffer_on,
	output logic divider_sync_pulse,
	// datapath settings
	output tsn_patterns_t patterns,
	output tsn_chan_cfg_t chan_cfg [TSN_NUM_CHAN]
);

	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [1:0] chan_index_q; // write steering, bit per channel
	logic [7:0] tp2_low_q, tp2_high_q, tp3_low_q, tp3_high_q, tp4_low_q, tp4_high_q;
	logic [2:0] sync_ctrl_q; // open bits read zero
	logic [3:0] req_ctrl_q [TSN_NUM_CHAN];
	logic [5:0] req_tune_q [TSN_NUM_CHAN];
	logic sync_meta_q, sync_sync_q, sync_prev_q; // pin synchroniser
	logic sync_edge; // rising edge of synchronised pin
	logic sync_gate; // divider sync allowed

	// ----------------------------------------
	// channel index
	// ----------------------------------------
	// kept here because it steers the per-channel writes
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			chan_index_q <= TSN_RST_CHAN_INDEX;
		end else if (reg_wr && reg_addr == TSN_ADDR_CHAN_INDEX) begin
			chan_index_q <= reg_wdata[1:0];
		end
	end

	// ----------------------------------------
	// shared test patterns
	// ----------------------------------------
	// one copy for both channels, whatever the index says
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tp2_low_q <= TSN_RST_BYTE;
			tp2_high_q <= TSN_RST_BYTE;
			tp3_low_q <= TSN_RST_BYTE;
			tp3_high_q <= TSN_RST_BYTE;
			tp4_low_q <= TSN_RST_BYTE;
			tp4_high_q <= TSN_RST_BYTE;
		end else if (reg_wr) begin
			unique case (reg_addr)
				TSN_ADDR_TP2_LOW: tp2_low_q <= reg_wdata;
				TSN_ADDR_TP2_HIGH: tp2_high_q <= reg_wdata;
				TSN_ADDR_TP3_LOW: tp3_low_q <= reg_wdata;
				TSN_ADDR_TP3_HIGH: tp3_high_q <= reg_wdata;
				TSN_ADDR_TP4_LOW: tp4_low_q <= reg_wdata;
				TSN_ADDR_TP4_HIGH: tp4_high_q <= reg_wdata;
				default: ; // other addresses belong elsewhere
			endcase
		end
	end

	// pattern words straight from the byte flops
	assign patterns = '{pattern_two: {tp2_high_q, tp2_low_q},
		pattern_three: {tp3_high_q, tp3_low_q},
		pattern_four: {tp4_high_q, tp4_low_q}};

	// ----------------------------------------
	// per-channel requantizer registers
	// ----------------------------------------
	// the host is trusted to leave index 0x03 around writes of 0x00
	for (genvar ch = 0; ch < TSN_NUM_CHAN; ch++) begin : g_chan
		logic [3:0] req_ctrl_d; // next control value
		logic [5:0] req_tune_d; // next tuning word
		logic [5:0] word_limit; // legal word count for the next mode
		logic word_valid_q; // registered so the output leaves a flop

		// next values, taken only when this channel is indexed
		always_comb begin
			req_ctrl_d = req_ctrl_q[ch];
			req_tune_d = req_tune_q[ch];
			if (reg_wr && chan_index_q[ch]) begin
				if (reg_addr == TSN_ADDR_REQ_CTRL) begin
					req_ctrl_d = reg_wdata[TSN_REQ_MODE_MSB:0];
				end
				if (reg_addr == TSN_ADDR_REQ_TUNE) begin
					req_tune_d = reg_wdata[TSN_TUNE_MSB:0];
				end
			end
		end

		// word validity judged on the next values, so it moves with the fields
		always_comb begin
			unique case (req_ctrl_d[TSN_REQ_MODE_MSB:TSN_REQ_MODE_LSB])
				TSN_BW_22PCT: word_limit = TSN_WORDS_22PCT;
				TSN_BW_33PCT: word_limit = TSN_WORDS_33PCT;
				default: word_limit = 6'h3F; // other mode codes flag only word 0x3F invalid
			endcase
		end

		// control, tuning word and its validity flag
		always_ff @(posedge ref_clk or negedge reset_n) begin
			if (!reset_n) begin
				req_ctrl_q[ch] <= TSN_RST_BYTE[3:0];
				req_tune_q[ch] <= TSN_RST_BYTE[5:0];
				word_valid_q <= (TSN_RST_BYTE[5:0] < TSN_WORDS_22PCT);
			end else begin
				req_ctrl_q[ch] <= req_ctrl_d;
				req_tune_q[ch] <= req_tune_d;
				word_valid_q <= (req_tune_d < word_limit);
			end
		end

		// each word step moves the band edge by half a percent of the sample rate
		assign chan_cfg[ch] = '{
			requantizer_on: req_ctrl_q[ch][TSN_REQ_ON_BIT],
			requantizer_bandwidth_select:
				req_ctrl_q[ch][TSN_REQ_MODE_MSB:TSN_REQ_MODE_LSB],
			requantizer_band_edge_word: req_tune_q[ch],
			word_valid: word_valid_q};
	end

	// ----------------------------------------
	// sync pin synchroniser
	// ----------------------------------------
	// first stage feeds only the second
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_meta_q <= 1'b0;
			sync_sync_q <= 1'b0;
			sync_prev_q <= 1'b0;
		end else begin
			sync_meta_q <= sync_pin;
			sync_sync_q <= sync_meta_q;
			sync_prev_q <= sync_sync_q;
		end
	end

	assign sync_edge = sync_sync_q && !sync_prev_q;
	assign sync_gate = sync_ctrl_q[TSN_SYNC_MASTER_BIT] && sync_ctrl_q[TSN_SYNC_DIV_EN_BIT];

	// ----------------------------------------
	// sync control
	// ----------------------------------------
	// next-sync-only drops the divider enable after one pass;
	// a host write in the same cycle wins so software intent is kept
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_ctrl_q <= TSN_RST_BYTE[2:0];
		end else if (reg_wr && reg_addr == TSN_ADDR_SYNC_CTRL) begin
			sync_ctrl_q <= reg_wdata[2:0];
		end else if (sync_edge && sync_gate && sync_ctrl_q[TSN_SYNC_NEXT_ONLY_BIT]) begin
			sync_ctrl_q[TSN_SYNC_DIV_EN_BIT] <= 1'b0;
		end
	end

	// divider pulse and buffer power, both registered
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			divider_sync_pulse <= 1'b0;
			sync_buffer_on <= 1'b0;
		end else begin
			divider_sync_pulse <= sync_edge && sync_gate;
			sync_buffer_on <= sync_ctrl_q[TSN_SYNC_MASTER_BIT];
		end
	end

	// ----------------------------------------
	// read back
	// ----------------------------------------
	// per-channel reads show channel A unless only B is indexed
	logic rd_ch;
	assign rd_ch = (chan_index_q == 2'h2);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= TSN_RST_BYTE;
		end else if (reg_rd) begin
			unique case (reg_addr)
				TSN_ADDR_CHAN_INDEX: reg_rdata <= {6'h00, chan_index_q};
				TSN_ADDR_TP2_LOW: reg_rdata <= tp2_low_q;
				TSN_ADDR_TP2_HIGH: reg_rdata <= tp2_high_q;
				TSN_ADDR_TP3_LOW: reg_rdata <= tp3_low_q;
				TSN_ADDR_TP3_HIGH: reg_rdata <= tp3_high_q;
				TSN_ADDR_TP4_LOW: reg_rdata <= tp4_low_q;
				TSN_ADDR_TP4_HIGH: reg_rdata <= tp4_high_q;
				TSN_ADDR_SYNC_CTRL: reg_rdata <= {5'h00, sync_ctrl_q};
				TSN_ADDR_REQ_CTRL: reg_rdata <= {4'h0, req_ctrl_q[rd_ch]};
				TSN_ADDR_REQ_TUNE: reg_rdata <= {2'h0, req_tune_q[rd_ch]};
				default: reg_rdata <= TSN_RST_BYTE; // unmapped reads zero
			endcase
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	sequence s_tp_write(logic [7:0] a);
		reg_wr && reg_addr == a;
	endsequence

	a_tp2_low_store: assert property (s_tp_write(TSN_ADDR_TP2_LOW) |=>
		patterns.pattern_two[7:0] == $past(reg_wdata))
		else $error("pattern two low byte not stored");
	a_tp3_high_store: assert property (s_tp_write(TSN_ADDR_TP3_HIGH) |=>
		patterns.pattern_three[15:8] == $past(reg_wdata))
		else $error("pattern three high byte not stored");
	a_tp4_low_store: assert property (s_tp_write(TSN_ADDR_TP4_LOW) |=>
		patterns.pattern_four[7:0] == $past(reg_wdata))
		else $error("pattern four low byte not stored");
	a_mode_field: assert property (reg_wr && reg_addr == TSN_ADDR_REQ_CTRL && chan_index_q[0]
		|=> chan_cfg[0].requantizer_bandwidth_select == $past(reg_wdata[3:1]))
		else $error("mode field wrong");
	a_tune_store: assert property (reg_wr && reg_addr == TSN_ADDR_REQ_TUNE && chan_index_q[1]
		|=> chan_cfg[1].requantizer_band_edge_word == $past(reg_wdata[5:0]))
		else $error("tuning word wrong");
	a_chan_steer: assert property (reg_wr && !chan_index_q[1]
		|=> $stable(chan_cfg[1].requantizer_band_edge_word))
		else $error("unindexed channel changed");
	a_master_gate: assert property (!sync_ctrl_q[0] |=> !divider_sync_pulse)
		else $error("sync passed with master off");
	a_sync_pass: assert property (sync_edge && sync_gate |=> divider_sync_pulse)
		else $error("gated sync pulse missing");
	a_on_bit: assert property (reg_wr && reg_addr == TSN_ADDR_REQ_CTRL && chan_index_q[0]
		|=> chan_cfg[0].requantizer_on == $past(reg_wdata[0]))
		else $error("enable bit wrong");
	a_word_valid: assert property (chan_cfg[0].requantizer_bandwidth_select == TSN_BW_33PCT
		&& chan_cfg[0].requantizer_band_edge_word == 6'h22 |-> !chan_cfg[0].word_valid)
		else $error("word 34 valid in 33 percent mode");

endmodule

`default_nettype wire

// ==== tsn_pkg.sv ====
package tsn_pkg;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] TSN_ADDR_CHAN_INDEX = 8'h05;
	localparam logic [7:0] TSN_ADDR_TP2_LOW = 8'h1B;
	localparam logic [7:0] TSN_ADDR_TP2_HIGH = 8'h1C;
	localparam logic [7:0] TSN_ADDR_TP3_LOW = 8'h1D;
	localparam logic [7:0] TSN_ADDR_TP3_HIGH = 8'h1E;
	localparam logic [7:0] TSN_ADDR_TP4_LOW = 8'h1F;
	localparam logic [7:0] TSN_ADDR_TP4_HIGH = 8'h20;
	localparam logic [7:0] TSN_ADDR_SYNC_CTRL = 8'h3A;
	localparam logic [7:0] TSN_ADDR_REQ_CTRL = 8'h3C;
	localparam logic [7:0] TSN_ADDR_REQ_TUNE = 8'h3E;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] TSN_RST_BYTE = 8'h00;
	localparam logic [1:0] TSN_RST_CHAN_INDEX = 2'h3;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int TSN_SYNC_MASTER_BIT = 0;
	localparam int TSN_SYNC_DIV_EN_BIT = 1;
	localparam int TSN_SYNC_NEXT_ONLY_BIT = 2;
	localparam int TSN_REQ_ON_BIT = 0;
	localparam int TSN_REQ_MODE_LSB = 1;
	localparam int TSN_REQ_MODE_MSB = 3;
	localparam int TSN_TUNE_MSB = 5;

	// ----------------------------------------
	// bandwidth modes and tuning word limits
	// ----------------------------------------
	localparam logic [2:0] TSN_BW_22PCT = 3'h0;
	localparam logic [2:0] TSN_BW_33PCT = 3'h1;
	localparam logic [5:0] TSN_WORDS_22PCT = 6'h39;
	localparam logic [5:0] TSN_WORDS_33PCT = 6'h22;
	localparam int TSN_NUM_CHAN = 2;

	// per-channel requantizer settings
	typedef struct packed {
		logic requantizer_on;
		logic [2:0] requantizer_bandwidth_select;
		logic [5:0] requantizer_band_edge_word;
		logic word_valid;
	} tsn_chan_cfg_t;

	// shared test patterns
	typedef struct packed {
		logic [15:0] pattern_two;
		logic [15:0] pattern_three;
		logic [15:0] pattern_four;
	} tsn_patterns_t;

endpackage

// ==== tsn_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// host side of the register port
// ----------------------------------------
// drives only on the falling edge, so the design samples settled values
module tsn_host_model
	import tsn_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// register port
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// external sync
	output logic sync_pin
);
	logic [1:0] idx_q; // host copy of the channel index

	// idle levels from time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		sync_pin = 1'b0;
		idx_q = TSN_RST_CHAN_INDEX;
	end

	// one write strobe of one cycle, after an index restore strobe when writing 0x00 with index not 0x03
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		if (a == 8'h00 && idx_q != 2'h3) begin
			wr(TSN_ADDR_CHAN_INDEX, 8'h03); // restore default index first
		end
		if (a == TSN_ADDR_CHAN_INDEX) begin
			idx_q = d[1:0];
		end
		@(negedge ref_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
		reg_wdata = ~d; // stale data would hide a missed strobe
	endtask

	// read strobe, data taken one full cycle later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask

	// pin high for two cycles, then back low; re-arm time is left to the caller
	task automatic sync_edge();
		@(negedge ref_clk);
		sync_pin = 1'b1;
		repeat (2) @(negedge ref_clk);
		sync_pin = 1'b0;
	endtask
endmodule

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
	$display("FAIL %s exp %0h got %0h", nm, e, g); end end

module tb
	import tsn_pkg::*;
;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic ref_clk, reset_n;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic reg_wr, reg_rd, sync_pin, sync_buffer_on, divider_sync_pulse;
	tsn_patterns_t patterns;
	tsn_chan_cfg_t chan_cfg [TSN_NUM_CHAN];
	int fails, n_tests, np;
	// mapped shared and per-channel registers except the channel index, patterns first
	logic [7:0] regs [9] = '{TSN_ADDR_TP2_LOW, TSN_ADDR_TP2_HIGH, TSN_ADDR_TP3_LOW,
		TSN_ADDR_TP3_HIGH, TSN_ADDR_TP4_LOW, TSN_ADDR_TP4_HIGH, TSN_ADDR_SYNC_CTRL,
		TSN_ADDR_REQ_CTRL, TSN_ADDR_REQ_TUNE};
	// sync table: control value, pulses on two tries, readback after
	logic [7:0] s_ctl [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07};
	int s_one [5] = '{0, 0, 0, 1, 1};
	int s_two [5] = '{0, 0, 0, 1, 0};
	logic [7:0] s_rb [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05};

	tsn_regs tsn_regs_i (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sync_pin(sync_pin), .sync_buffer_on(sync_buffer_on),
		.divider_sync_pulse(divider_sync_pulse), .patterns(patterns), .chan_cfg(chan_cfg));
	tsn_host_model tsn_host_model_i (.ref_clk(ref_clk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sync_pin(sync_pin));

	// ----------------------------------------
	// clock, verdict, watchdog
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// single exit point of the run
	task automatic final_report();
		if (fails == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// tests take about 240 cycles; give them twenty times that
	initial begin
		#125000;
		fails++;
		final_report();
	end

	// fire the pin and count divider pulses over ten cycles
	task automatic fire(output int n);
		n = 0;
		fork
			tsn_host_model_i.sync_edge();
			repeat (10) @(negedge ref_clk) n += (divider_sync_pulse === 1'b1);
		join
	endtask

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		fails = 0;
		n_tests = 0;
		reset_n = 1'b0;
		repeat (10) @(negedge ref_clk);
		reset_n = 1'b1;
		// reset values of every register
		foreach (regs[i]) begin
			tsn_host_model_i.rd(regs[i], d);
			`CHK("reset", 8'h00, d)
		end
		tsn_host_model_i.rd(TSN_ADDR_CHAN_INDEX, d);
		`CHK("index reset", 8'h03, d)
		// pattern bytes land independently, {high, low}
		for (int i = 0; i < 6; i++) tsn_host_model_i.wr(regs[i], 8'hA0 + 8'(i));
		`CHK("patterns", 48'hA1A0_A3A2_A5A4, patterns)
		foreach (regs[i]) if (i < 6) begin
			tsn_host_model_i.rd(regs[i], d);
			`CHK("pattern rb", 8'hA0 + 8'(i), d)
		end
		// unmapped place ignores writes
		tsn_host_model_i.wr(8'h30, 8'hFF);
		tsn_host_model_i.rd(8'h30, d);
		`CHK("unmapped", 8'h00, d)
		// channel A only: on, 33% mode, words around the limit of 34
		tsn_host_model_i.wr(TSN_ADDR_CHAN_INDEX, 8'h01);
		tsn_host_model_i.wr(TSN_ADDR_REQ_CTRL, 8'hF3);
		tsn_host_model_i.wr(TSN_ADDR_REQ_TUNE, 8'hE1);
		tsn_host_model_i.rd(TSN_ADDR_REQ_CTRL, d);
		`CHK("ctrl rb", 8'h03, d)
		tsn_host_model_i.rd(TSN_ADDR_REQ_TUNE, d);
		`CHK("tune rb", 8'h21, d)
		`CHK("cfg a", 11'b1_001_100001_1, chan_cfg[0])
		`CHK("cfg b", 11'b0_000_000000_1, chan_cfg[1])
		tsn_host_model_i.wr(TSN_ADDR_REQ_TUNE, 8'h22);
		`CHK("a word 34", 1'b0, chan_cfg[0].word_valid)
		// channel B only: 22% mode, words around the limit of 57
		tsn_host_model_i.wr(TSN_ADDR_CHAN_INDEX, 8'h02);
		tsn_host_model_i.wr(TSN_ADDR_REQ_CTRL, 8'h01);
		tsn_host_model_i.wr(TSN_ADDR_REQ_TUNE, 8'h38);
		`CHK("cfg b2", 11'b1_000_111000_1, chan_cfg[1])
		tsn_host_model_i.wr(TSN_ADDR_REQ_TUNE, 8'h39);
		`CHK("b word 57", 1'b0, chan_cfg[1].word_valid)
		`CHK("a kept", 6'h22, chan_cfg[0].requantizer_band_edge_word)
		// a write to 0x00 while only B is indexed restores the default index
		tsn_host_model_i.wr(8'h00, 8'h00);
		tsn_host_model_i.rd(TSN_ADDR_CHAN_INDEX, d);
		`CHK("index kept", 8'h03, d)
		// both channels at once
		tsn_host_model_i.wr(TSN_ADDR_CHAN_INDEX, 8'h03);
		tsn_host_model_i.wr(TSN_ADDR_REQ_TUNE, 8'h10);
		`CHK("both", 12'h410, {chan_cfg[0].requantizer_band_edge_word,
			chan_cfg[1].requantizer_band_edge_word})
		// sync gating: off, master only, divider only, continuous, next only
		foreach (s_ctl[i]) begin
			tsn_host_model_i.wr(TSN_ADDR_SYNC_CTRL, s_ctl[i]);
			// buffer power is one flop behind the control register
			@(negedge ref_clk);
			`CHK("buffer on", s_ctl[i][0], sync_buffer_on)
			fire(np);
			`CHK("pulses 1", s_one[i], np)
			fire(np);
			`CHK("pulses 2", s_two[i], np)
			tsn_host_model_i.rd(TSN_ADDR_SYNC_CTRL, d);
			`CHK("sync rb", s_rb[i], d)
		end
		final_report();
	end
endmodule

`default_nettype wire
